/* File: rtl/clic_defs.vh */
// Constants shared by the character display instruction core.
`ifndef CLIC_DEFS_VH
`define CLIC_DEFS_VH

// Core clock period in ns (20 MHz).
`define CLIC_CLK_NS 50
// Execution time of shift, format and address commands, ns.
`define CLIC_T_CMD_NS 39000
// Execution time of a RAM data write or read, ns.
`define CLIC_T_DATA_NS 43000
// Width of the busy counter.
`define CLIC_CNT_W 10

// Instruction byte field positions.
`define CLIC_B_TARGET 3
`define CLIC_B_DIR 2
`define CLIC_B_WIDTH 4
`define CLIC_B_LINES 3
`define CLIC_B_FONT 2

// Pointer limits for the character RAM map.
`define CLIC_ONE_END 7'h4f
`define CLIC_L1_END 7'h27
`define CLIC_L2_BASE 7'h40
`define CLIC_L2_END 7'h67
`define CLIC_PTR_ZERO 7'h00
// Window offset wrap points for one and two lines.
`define CLIC_OFS_ONE_END 7'h4f
`define CLIC_OFS_TWO_END 7'h27

// Software port register offsets.
`define CLIC_REG_CTRL 4'h0
`define CLIC_REG_STAT 4'h1
`define CLIC_REG_CFG 4'h2
`define CLIC_REG_OFS 4'h3
// Control register bits.
`define CLIC_CTRL_INC 0
`define CLIC_CTRL_SCROLL 1
// Reset values.
`define CLIC_INC_RST 1'b1
`define CLIC_SCROLL_RST 1'b0
`define CLIC_WIDTH_RST 1'b1

`endif

/* File: rtl/clic_core.v */
// Instruction decoder, address pointer and RAMs of a character display.
//
// Chosen here: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
`include "clic_defs.vh"

module clic_core (
  // Clock and reset.
  input wire core_clk,
  input wire srst,
  // Parallel host pins.
  input wire reg_select,
  input wire rw_sel,
  input wire strobe,
  input wire [7:0] bus_in,
  output reg [7:0] bus_out,
  output reg bus_oe,
  // Software register port.
  input wire [3:0] sw_addr,
  input wire [7:0] sw_wdata,
  input wire sw_wr,
  input wire sw_rd,
  output reg [7:0] sw_rdata,
  // Display status.
  output reg busy_indicator,
  output reg two_line,
  output reg font_tall,
  output reg [6:0] win_ofs
);

  // Cycle counts derived from the times, rounded up.
  localparam integer CMD_NUM =
    (`CLIC_T_CMD_NS + `CLIC_CLK_NS - 1) / `CLIC_CLK_NS;
  localparam integer DATA_NUM =
    (`CLIC_T_DATA_NS + `CLIC_CLK_NS - 1) / `CLIC_CLK_NS;
  // Counter-width copies; both counts fit the busy counter.
  localparam [`CLIC_CNT_W-1:0] CMD_CYC = CMD_NUM[`CLIC_CNT_W-1:0];
  localparam [`CLIC_CNT_W-1:0] DATA_CYC = DATA_NUM[`CLIC_CNT_W-1:0];

  // Two-flop synchronisers for the host pins.
  reg rs_m, rs_s;
  reg rw_m, rw_s;
  reg en_m, en_s;
  reg [7:0] db_m, db_s;
  // Delayed strobe for edge detection.
  reg en_d;

  // Interface state.
  reg bus_width_sel; // 1 for eight lanes, 0 for four.
  reg phase; // Set after the first nibble of a pair.
  reg [3:0] hi_nib; // Held upper nibble of a write.

  // Address pointer and target RAM.
  reg [6:0] address_pointer;
  reg glyph_sel; // 1 when data goes to glyph RAM.

  // Software controls.
  reg entry_inc; // Step direction after data access.
  reg auto_scroll; // Scroll window on char writes.

  // Busy timing and deferred work.
  reg [`CLIC_CNT_W-1:0] busy_cnt;
  reg step_pend; // Pointer step waits for busy end.
  reg load_pend; // Read buffer refill after busy end.
  reg fetch; // One-cycle refill of the read buffer.
  reg [7:0] rd_buf; // Byte returned by a data read.

  // The two internal RAMs.
  // Character RAM covers the full seven-bit pointer range.
  reg [7:0] char_ram [0:127];
  // Glyph RAM covers the six-bit pointer range.
  reg [7:0] glyph_ram [0:63];

  // Strobe edge and the assembled byte.
  wire fall = en_d & ~en_s;
  wire last = bus_width_sel | phase;
  wire [7:0] wbyte = bus_width_sel ? db_s : {hi_nib, db_s[7:4]};

  // Step the pointer within the map of the selected RAM.
  function [6:0] step_ptr;
    input [6:0] p;
    input inc;
    input two;
    input gly;
    begin
      // Glyph RAM wraps within its six address bits.
      if (gly) begin
        step_ptr = {1'b0, p[5:0] + (inc ? 6'h01 : 6'h3f)};
      end else if (!two) begin
        // One line is a single run that wraps at both ends.
        if (inc) begin
          step_ptr = (p >= `CLIC_ONE_END) ? `CLIC_PTR_ZERO :
            p + 7'h01;
        end else begin
          step_ptr = (p == `CLIC_PTR_ZERO) ? `CLIC_ONE_END :
            p - 7'h01;
        end
      end else if (inc) begin
        // Two lines counting up jump the gap to the second line.
        if (p == `CLIC_L1_END) begin
          step_ptr = `CLIC_L2_BASE;
        end else if (p >= `CLIC_L2_END) begin
          step_ptr = `CLIC_PTR_ZERO;
        end else begin
          step_ptr = p + 7'h01;
        end
      end else begin
        // Counting down jumps the gap back to the first line.
        if (p == `CLIC_L2_BASE) begin
          step_ptr = `CLIC_L1_END;
        end else if (p == `CLIC_PTR_ZERO) begin
          step_ptr = `CLIC_L2_END;
        end else begin
          step_ptr = p - 7'h01;
        end
      end
    end
  endfunction

  // Move the shared window offset left (up) or right (down).
  function [6:0] step_ofs;
    input [6:0] o;
    input left;
    input two;
    reg [6:0] top;
    begin
      // The window range depends on the line count.
      top = two ? `CLIC_OFS_TWO_END : `CLIC_OFS_ONE_END;
      if (left) begin
        // Left moves the window start up, wrapping to zero.
        step_ofs = (o >= top) ? 7'h00 : o + 7'h01;
      end else begin
        // Right moves it down, wrapping to the last column.
        step_ofs = (o == 7'h00) ? top : o - 7'h01;
      end
    end
  endfunction

  // Synchronise the asynchronous host pins before any use.
  always @(posedge core_clk) begin
    if (srst) begin
      // Clear every stage so no false strobe edge follows reset.
      rs_m <= 1'b0;
      rs_s <= 1'b0;
      rw_m <= 1'b0;
      rw_s <= 1'b0;
      en_m <= 1'b0;
      en_s <= 1'b0;
      en_d <= 1'b0;
      db_m <= 8'h00;
      db_s <= 8'h00;
    end else begin
      // Two stages per pin, one more on the strobe for its edge.
      rs_m <= reg_select;
      rs_s <= rs_m;
      rw_m <= rw_sel;
      rw_s <= rw_m;
      en_m <= strobe;
      en_s <= en_m;
      en_d <= en_s;
      db_m <= bus_in;
      db_s <= db_m;
    end
  end

  // Drive read data while the strobe is high, upper nibble first.
  always @(posedge core_clk) begin
    if (srst) begin
      bus_out <= 8'h00;
      bus_oe <= 1'b0;
    end else begin
      bus_oe <= en_s & rw_s;
      if (!rs_s) begin
        // Busy and pointer readback is always allowed.
        // Full byte, or the upper nibble of a four-lane pair.
        if (bus_width_sel || !phase) begin
          bus_out <= {busy_indicator, address_pointer};
        end else begin
          bus_out <= {address_pointer[3:0], 4'h0};
        end
      end else if (bus_width_sel || !phase) begin
        // Data reads return the buffered byte, not the RAM.
        bus_out <= rd_buf;
      end else begin
        bus_out <= {rd_buf[3:0], 4'h0};
      end
    end
  end

  // RAM writes happen when an accepted data write completes.
  always @(posedge core_clk) begin
    if (fall && last && !rw_s && rs_s && !busy_indicator) begin
      // The byte lands at the pointer before any step.
      if (glyph_sel) begin
        // Only the low six pointer bits reach the glyph RAM.
        glyph_ram[address_pointer[5:0]] <= wbyte;
      end else begin
        char_ram[address_pointer] <= wbyte;
      end
    end
  end

  // Instruction execution, pointer, busy timing and read buffer.
  always @(posedge core_clk) begin
    if (srst) begin
      // Eight-lane bus, pointer at zero, char RAM target.
      bus_width_sel <= `CLIC_WIDTH_RST;
      phase <= 1'b0;
      hi_nib <= 4'h0;
      address_pointer <= `CLIC_PTR_ZERO;
      glyph_sel <= 1'b0;
      two_line <= 1'b0;
      font_tall <= 1'b0;
      win_ofs <= 7'h00;
      busy_indicator <= 1'b0;
      busy_cnt <= {`CLIC_CNT_W{1'b0}};
      step_pend <= 1'b0;
      load_pend <= 1'b0;
      fetch <= 1'b0;
      rd_buf <= 8'h00;
    end else begin
      fetch <= 1'b0;
      // Refill the read buffer from the current pointer.
      if (fetch) begin
        rd_buf <= glyph_sel ? glyph_ram[address_pointer[5:0]] :
          char_ram[address_pointer];
      end
      // Count down execution time, then do the deferred work.
      if (busy_indicator) begin
        if (busy_cnt == {{(`CLIC_CNT_W-1){1'b0}}, 1'b1}) begin
          // Last busy cycle: release busy, do the deferred step.
          busy_indicator <= 1'b0;
          if (step_pend) begin
            address_pointer <= step_ptr(address_pointer,
              entry_inc, two_line, glyph_sel);
          end
          step_pend <= 1'b0;
          fetch <= load_pend;
          load_pend <= 1'b0;
        end
        busy_cnt <= busy_cnt - {{(`CLIC_CNT_W-1){1'b0}}, 1'b1};
      end
      // Each strobe fall moves one transfer or nibble.
      if (fall) begin
        if (!last) begin
          // First nibble of a four-lane pair.
          phase <= 1'b1;
          hi_nib <= db_s[7:4];
        end else begin
          // The transfer completes with this fall.
          phase <= 1'b0;
          if (busy_indicator) begin
            // Requests other than readback are dropped.
          end else if (rs_s && rw_s) begin
            // Data read done: step later, refill, never scroll.
            busy_indicator <= 1'b1;
            busy_cnt <= DATA_CYC;
            step_pend <= 1'b1;
            load_pend <= 1'b1;
          end else if (rs_s) begin
            // Data write: RAM store is in its own process.
            busy_indicator <= 1'b1;
            busy_cnt <= DATA_CYC;
            step_pend <= 1'b1;
            if (auto_scroll && !glyph_sel) begin
              win_ofs <= step_ofs(win_ofs, entry_inc, two_line);
            end
          end else if (!rw_s) begin
            // Instruction write; every command holds busy.
            busy_indicator <= 1'b1;
            busy_cnt <= CMD_CYC;
            casez (wbyte)
              8'b1???????: begin
                // Character RAM address load.
                address_pointer <= wbyte[6:0];
                glyph_sel <= 1'b0;
                load_pend <= 1'b1;
              end
              8'b01??????: begin
                // Glyph RAM address load.
                address_pointer <= {1'b0, wbyte[5:0]};
                glyph_sel <= 1'b1;
                load_pend <= 1'b1;
              end
              8'b001?????: begin
                // Bus width, line count and font.
                bus_width_sel <= wbyte[`CLIC_B_WIDTH];
                two_line <= wbyte[`CLIC_B_LINES];
                font_tall <= wbyte[`CLIC_B_FONT];
              end
              8'b0001????: begin
                // Cursor or display shift.
                if (wbyte[`CLIC_B_TARGET]) begin
                  // Whole window, all lines, pointer kept.
                  win_ofs <= step_ofs(win_ofs,
                    !wbyte[`CLIC_B_DIR], two_line);
                end else begin
                  // Cursor step is immediate; refill follows busy.
                  address_pointer <= step_ptr(address_pointer,
                    wbyte[`CLIC_B_DIR], two_line, glyph_sel);
                  load_pend <= 1'b1;
                end
              end
              default: begin
                // Commands outside this core only take time.
              end
            endcase
          end
        end
      end
    end
  end

  // Software controls for entry direction and scrolling.
  always @(posedge core_clk) begin
    if (srst) begin
      entry_inc <= `CLIC_INC_RST;
      auto_scroll <= `CLIC_SCROLL_RST;
    end else if (sw_wr && sw_addr == `CLIC_REG_CTRL) begin
      // Only the control register is writable.
      entry_inc <= sw_wdata[`CLIC_CTRL_INC];
      auto_scroll <= sw_wdata[`CLIC_CTRL_SCROLL];
    end
  end

  // Software read data, valid the cycle after the strobe.
  always @(posedge core_clk) begin
    if (srst) begin
      sw_rdata <= 8'h00;
    end else if (sw_rd) begin
      case (sw_addr)
        `CLIC_REG_CTRL: sw_rdata <= {6'h00, auto_scroll, entry_inc};
        `CLIC_REG_STAT: sw_rdata <= {busy_indicator, address_pointer};
        `CLIC_REG_CFG: sw_rdata <= {4'h0, glyph_sel, font_tall,
          two_line, bus_width_sel};
        `CLIC_REG_OFS: sw_rdata <= {1'b0, win_ofs};
        default: sw_rdata <= 8'h00;
      endcase
    end else begin
      // Idle cycles read as zero.
      sw_rdata <= 8'h00;
    end
  end

endmodule

/* File: tb/clic_chk.sv */
// Assertion checker for the character display instruction core.
`timescale 1ns/100ps
module clic_chk (
  // Clock and reset.
  input wire core_clk,
  input wire srst,
  // Host pins.
  input wire rw_sel,
  input wire strobe,
  input wire bus_oe,
  // Software port.
  input wire [3:0] sw_addr,
  input wire sw_rd,
  input wire [7:0] sw_rdata,
  // Status.
  input wire busy_indicator,
  input wire two_line,
  input wire font_tall,
  input wire [6:0] win_ofs
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  // Length of the current busy period in cycles.
  reg [10:0] blen;
  always @(posedge core_clk) begin
    if (srst || !busy_indicator) begin
      blen <= 11'h000;
    end else begin
      blen <= blen + 11'h001;
    end
  end
  property p_blen;
    $fell(busy_indicator) |-> blen == 11'd780 || blen == 11'd860;
  endproperty
  a_blen: assert property (p_blen) else $error("busy length wrong");
  property p_bhold;
    $rose(busy_indicator) |-> busy_indicator [*8];
  endproperty
  a_bhold: assert property (p_bhold) else $error("busy too short");
  property p_stat;
    $past(sw_rd) && $past(sw_addr) == 4'h1
      |-> sw_rdata[7] == $past(busy_indicator);
  endproperty
  a_stat: assert property (p_stat) else $error("status busy bit");
  property p_oe_rw;
    bus_oe |-> $past(rw_sel, 3);
  endproperty
  a_oe_rw: assert property (p_oe_rw) else $error("drive on write");
  property p_oe_stb;
    $rose(bus_oe) |-> $past(strobe, 3);
  endproperty
  a_oe_stb: assert property (p_oe_stb) else $error("drive no strobe");
  property p_line;
    $changed(two_line) |-> $rose(busy_indicator);
  endproperty
  a_line: assert property (p_line) else $error("line change");
  property p_font;
    $changed(font_tall) |-> $rose(busy_indicator);
  endproperty
  a_font: assert property (p_font) else $error("font change");
  property p_ofs;
    win_ofs <= (two_line ? 7'h27 : 7'h4f);
  endproperty
  a_ofs: assert property (p_ofs) else $error("offset range");
  property p_ofs_chg;
    $changed(win_ofs) |-> $rose(busy_indicator) || $fell(busy_indicator);
  endproperty
  a_ofs_chg: assert property (p_ofs_chg) else $error("offset moved");
  // Main scenarios.
  c_two: cover property ($rose(busy_indicator) && two_line);
  c_oe: cover property ($rose(bus_oe));
  c_ofs: cover property ($changed(win_ofs));
endmodule
bind clic_core clic_chk i_clic_chk (.core_clk(core_clk), .srst(srst),
  .rw_sel(rw_sel), .strobe(strobe), .bus_oe(bus_oe), .sw_addr(sw_addr),
  .sw_rd(sw_rd), .sw_rdata(sw_rdata), .busy_indicator(busy_indicator),
  .two_line(two_line), .font_tall(font_tall), .win_ofs(win_ofs));

/* File: tb/clic_host.sv */
// Host processor model on the core's parallel pins.
`timescale 1ns/100ps
module clic_host (
  // Clock and read path.
  input wire core_clk,
  input wire [7:0] bus_out,
  // Pins towards the core.
  output reg reg_select = 1'b0,
  output reg rw_sel = 1'b0,
  output reg strobe = 1'b0,
  output reg [7:0] bus_in = 8'h00
);
  reg wide = 1'b1; // Bus width the host believes in.
  // One strobe; pins settle before the rise and hold past the fall.
  task automatic nib(input rs, rw, input [7:0] d, output [7:0] q);
    begin
      reg_select <= rs;
      rw_sel <= rw;
      bus_in <= d;
      repeat (4) @(posedge core_clk);
      strobe <= 1'b1;
      repeat (6) @(posedge core_clk);
      q = bus_out;
      strobe <= 1'b0;
      repeat (5) @(posedge core_clk);
      bus_in <= ~d; // Released lines do not keep the last value.
      @(posedge core_clk);
    end
  endtask
  // One byte, split into upper then lower nibble on a narrow bus.
  task automatic xfer(input rs, rw, input [7:0] d, output [7:0] q);
    reg [7:0] h;
    reg [7:0] l;
    begin
      if (wide) begin
        nib(rs, rw, d, q);
      end else begin
        nib(rs, rw, d, h);
        nib(rs, rw, {d[3:0], ~d[3:0]}, l);
        q = {h[7:4], l[7:4]};
      end
    end
  endtask
  // Polls the busy indicator; returns the pointer once idle.
  task automatic ready(output [6:0] p, output ok);
    reg [7:0] q;
    integer n;
    begin
      ok = 1'b0;
      for (n = 0; n < 120 && !ok; n = n + 1) begin
        xfer(1'b0, 1'b1, 8'h00, q);
        ok = !q[7];
      end
      p = q[6:0];
    end
  endtask
endmodule

/* File: tb/tb_clic_core.sv */
// Self-checking bench for the character display instruction core.
`timescale 1ns/100ps
module tb_clic_core;
  reg core_clk = 1'b0;
  reg srst = 1'b1;
  reg [3:0] sw_addr = 4'h0;
  reg [7:0] sw_wdata = 8'h00;
  reg sw_wr = 1'b0;
  reg sw_rd = 1'b0;
  wire [7:0] sw_rdata, bus_in, bus_out;
  wire reg_select, rw_sel, strobe, bus_oe, busy_indicator;
  wire two_line, font_tall;
  wire [6:0] win_ofs;
  integer miscompares = 0;
  integer tests_run = 0;
  reg [7:0] wq [$]; // Bytes written, in read-back order.
  reg [31:0] rnd = 32'h500e;
  reg [7:0] q;
  reg [6:0] p;
  reg ok;
  always #25 core_clk = ~core_clk;
  clic_core i_clic_core (.core_clk(core_clk), .srst(srst),
    .reg_select(reg_select), .rw_sel(rw_sel), .strobe(strobe),
    .bus_in(bus_in), .bus_out(bus_out), .bus_oe(bus_oe),
    .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
    .sw_rdata(sw_rdata), .busy_indicator(busy_indicator),
    .two_line(two_line), .font_tall(font_tall), .win_ofs(win_ofs));
  clic_host i_clic_host (.core_clk(core_clk), .bus_out(bus_out),
    .reg_select(reg_select), .rw_sel(rw_sel), .strobe(strobe),
    .bus_in(bus_in));
  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  task check(input [7:0] seen, input [7:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("unexpected at %0t: %h vs %h", $time, seen, exp);
      end
    end
  endtask
  task give_verdict;
    begin
      $display("counts: %0d run, %0d bad", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
        $display("STATUS OK");
      end else begin
        $display("STATUS NOT OK");
      end
      $finish;
    end
  endtask
  // Software port access; the read result lands in q.
  task sw_acc(input [3:0] a, input w, input [7:0] d);
    begin
      sw_addr <= a;
      sw_wdata <= d;
      sw_wr <= w;
      sw_rd <= !w;
      @(posedge core_clk);
      sw_wr <= 1'b0;
      sw_rd <= 1'b0;
      @(posedge core_clk);
      q = sw_rdata;
    end
  endtask
  // Instruction, then idle wait and pointer compare.
  task cmd(input [7:0] c, input [6:0] np);
    begin
      i_clic_host.xfer(1'b0, 1'b0, c, q);
      i_clic_host.ready(p, ok);
      check({7'h00, ok}, 8'h01);
      check({1'b0, p}, {1'b0, np});
    end
  endtask
  // Data access: writes a random byte, reads expect the oldest one.
  task dat(input rw, input [6:0] np);
    reg [7:0] d;
    begin
      rnd = xs(rnd);
      if (rw) begin
        d = wq.pop_front();
      end else begin
        d = rnd[7:0];
        wq.push_back(d);
      end
      i_clic_host.xfer(1'b1, rw, d, q);
      if (rw) check(q, d);
      i_clic_host.ready(p, ok);
      check({1'b0, p}, {1'b0, np});
    end
  endtask
  initial begin
    #(90000 * 50);
    miscompares = miscompares + 1;
    give_verdict;
  end
  initial begin
    repeat (20) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    sw_acc(4'h0, 1'b0, 8'h00);
    check(q, 8'h01);
    sw_acc(4'h2, 1'b0, 8'h00);
    check(q, 8'h01);
    sw_acc(4'h7, 1'b0, 8'h00);
    check(q, 8'h00);
    cmd(8'h3c, 7'h00);
    check({6'h00, font_tall, two_line}, 8'h03);
    $display("test format done");
    cmd(8'h85, 7'h05);
    cmd(8'h10, 7'h04);
    cmd(8'h14, 7'h05);
    cmd(8'h1c, 7'h05);
    check({1'b0, win_ofs}, 8'h27);
    cmd(8'h18, 7'h05);
    check({1'b0, win_ofs}, 8'h00);
    cmd(8'h0c, 7'h05);
    $display("test shift done");
    cmd(8'ha7, 7'h27);
    dat(1'b0, 7'h40);
    dat(1'b0, 7'h41);
    cmd(8'ha7, 7'h27);
    dat(1'b1, 7'h40);
    dat(1'b1, 7'h41);
    cmd(8'h7f, 7'h3f);
    dat(1'b0, 7'h00);
    cmd(8'h7f, 7'h3f);
    dat(1'b1, 7'h00);
    $display("test ram done");
    sw_acc(4'h0, 1'b1, 8'h03);
    cmd(8'h85, 7'h05);
    dat(1'b0, 7'h06);
    check({1'b0, win_ofs}, 8'h01);
    cmd(8'h10, 7'h05);
    dat(1'b1, 7'h06);
    check({1'b0, win_ofs}, 8'h01);
    sw_acc(4'h0, 1'b1, 8'h00);
    cmd(8'h80, 7'h00);
    dat(1'b0, 7'h67);
    cmd(8'h80, 7'h00);
    dat(1'b1, 7'h67);
    $display("test entry done");
    i_clic_host.xfer(1'b0, 1'b0, 8'h90, q);
    cmd(8'ha0, 7'h10);
    sw_acc(4'h1, 1'b0, 8'h00);
    check(q, 8'h10);
    sw_acc(4'h0, 1'b1, 8'h01);
    i_clic_host.xfer(1'b0, 1'b0, 8'h20, q);
    i_clic_host.wide = 1'b0;
    i_clic_host.ready(p, ok);
    check({7'h00, ok}, 8'h01);
    check({1'b0, p}, 8'h10);
    check({7'h00, two_line}, 8'h00);
    check({7'h00, font_tall}, 8'h00);
    cmd(8'hcf, 7'h4f);
    dat(1'b0, 7'h00);
    cmd(8'hcf, 7'h4f);
    dat(1'b1, 7'h00);
    $display("test nibble done");
    give_verdict;
  end
endmodule
